/* File: dv/tb_usb_accessory_detect_xcvr.sv */
`timescale 1ns/100ps
module tb_usb_accessory_detect_xcvr;
  import uadx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr, plug_state, toggle_count, tg;
  logic [31:0] pwdata, prdata, rd;
  logic        vbus_valid_comparator, vbus_session_high_comparator;
  logic        vbus_session_low_comparator, dp_above_thresh, dm_above_thresh;
  logic        id_float_det, id_gnd_det, id_special_det, rx_diff_in, rx_data;
  logic        xcvr_enable, xcvr_low_power, tx_driver_en, rx_receiver_en;
  logic        positive_data_line_o, negative_data_line_o, diff_bad, irq;
  logic        pullup_positive_en, pullup_negative_en, id_voltage_adc_channel;
  logic        tx_busy;
  logic [1:0]  data_mode, audio_mode;
  logic [11:0] e;
  logic [15:0] x;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          run = 0;
  int          n;
  logic [31:0] det [10] = '{32'h01010100, 32'h03030100, 32'h07070100,
    32'h06060100, 32'h0E060000, 32'h1E0E0200, 32'h16060200, 32'h36160402,
    32'h56260401, 32'h96060403};
  logic [8:0]  ctl [8] = '{9'h008, 9'h019, 9'h003, 9'h005, 9'h017, 9'h021,
    9'h149, 9'h08D};
  logic [7:0]  txb [4] = '{8'h00, 8'h55, 8'hFF, 8'hFF};
  wire  [4:0]  oa = {xcvr_enable, xcvr_low_power, tx_driver_en,
                     rx_receiver_en, rx_data};
  wire  [6:0]  ob = {data_mode, pullup_positive_en, pullup_negative_en,
                     audio_mode, id_voltage_adc_channel};
  uadx_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .vbus_valid_comparator,
    .vbus_session_high_comparator, .vbus_session_low_comparator,
    .dp_above_thresh, .dm_above_thresh, .id_float_det, .id_gnd_det,
    .id_special_det, .rx_diff_in, .rx_data, .xcvr_enable, .xcvr_low_power,
    .tx_driver_en, .rx_receiver_en, .positive_data_line_o,
    .negative_data_line_o, .data_mode, .pullup_positive_en,
    .pullup_negative_en, .audio_mode, .id_voltage_adc_channel, .tx_busy,
    .irq);
  uadx_acc_model u_acc (.pclk, .presetn, .plug_state,
    .vbus_valid_comparator, .vbus_session_high_comparator,
    .vbus_session_low_comparator, .dp_above_thresh, .dm_above_thresh,
    .id_float_det, .id_gnd_det, .id_special_det, .rx_diff_in,
    .positive_data_line_o, .negative_data_line_o, .tx_busy, .toggle_count,
    .diff_bad);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Catch a hung run well past the expected length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  // Bit count and line changes of one byte, stuffing run kept across bytes
  function automatic logic [15:0] stuff(input logic [7:0] b);
    logic [7:0] nb, tc;
    nb = 8'h00;
    tc = 8'h00;
    for (int k = 0; k < 8; k++) begin
      nb++;
      if (b[k]) begin
        run++;
        if (run == UADX_STUFF_RUN) begin
          nb++;
          tc++;
          run = 0;
        end
      end else begin
        tc++;
        run = 0;
      end
    end
    return {nb, tc};
  endfunction
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    plug_state = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(UADX_OFF_CTRL, 32'(UADX_CTRL_RST), "ctrl reset");
    rdc(UADX_OFF_MASK, 32'(UADX_MASK_RST), "mask reset");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, 32'(serr));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, UADX_OFF_MASK, 32'h7);
    foreach (det[i]) begin
      plug_state <= det[i][31:24];
      repeat (6) @(posedge pclk);
      rdc(UADX_OFF_SENSE, det[i][23:16], "sense");
      rdc(UADX_OFF_STAT, det[i][15:8], "status");
      chk("irq", 32'(det[i][15:8] != 8'h00), 32'(irq));
      rdc(UADX_OFF_PLUG, det[i][7:0], "plug");
      apb(1'b1, UADX_OFF_STAT, 32'h0);
      rdc(UADX_OFF_STAT, det[i][15:8], "sticky");
      apb(1'b1, UADX_OFF_STAT, 32'(det[i][15:8]));
      rdc(UADX_OFF_STAT, 32'h0, "cleared");
    end
    // Masked event stays pending but quiet
    apb(1'b1, UADX_OFF_MASK, 32'h0);
    plug_state <= 8'h00;
    repeat (6) @(posedge pclk);
    rdc(UADX_OFF_STAT, 32'h1, "pending");
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, UADX_OFF_MASK, 32'h1);
    @(posedge pclk);
    chk("irq unmasked", 32'h1, 32'(irq));
    apb(1'b1, UADX_OFF_SENSE, 32'h3F);
    rdc(UADX_OFF_SENSE, 32'h0, "sense ro");
    foreach (ctl[i]) begin
      e = {ctl[i][0], ctl[i][5], ctl[i][0] & ~ctl[i][3] & ~ctl[i][5],
           ctl[i][0] & ctl[i][3], ctl[i][0] & ctl[i][3], ctl[i][2],
           ctl[i][1], ctl[i][0] & ctl[i][4], ctl[i][0] & ~ctl[i][4],
           ctl[i][7], ctl[i][6], ctl[i][8]};
      apb(1'b1, UADX_OFF_CTRL, 32'(ctl[i]));
      repeat (5) @(posedge pclk);
      rdc(UADX_OFF_CTRL, 32'(ctl[i]), "ctrl");
      chk("xcvr", 32'(e[11:7]), 32'(oa));
      chk("mode", 32'(e[6:0]), 32'(ob));
    end
    // Suspended with receiver on, the raw line reaches the host
    apb(1'b1, UADX_OFF_CTRL, 32'h29);
    repeat (3) @(posedge pclk);
    chk("raw line high", 32'h1, 32'(rx_data));
    chk("suspended", 32'h1, 32'(xcvr_low_power));
    plug_state <= 8'h01;
    repeat (5) @(posedge pclk);
    chk("raw line low", 32'h0, 32'(rx_data));
    apb(1'b1, UADX_OFF_CTRL, 32'h11);
    foreach (txb[i]) begin
      tg = toggle_count;
      x = stuff(txb[i]);
      apb(1'b1, UADX_OFF_TXD, 32'(txb[i]));
      n = 0;
      while (tx_busy !== 1'b1 && n < 5) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      while (tx_busy === 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      repeat (2) @(posedge pclk);
      chk("bit cycles", 32'(x[15:8] * UADX_BIT_CYC), n);
      chk("toggles", 32'(x[7:0]), 32'(toggle_count - tg));
      chk("differential", 32'h0, 32'(diff_bad));
    end
    close_out();
  end
endmodule // tb_usb_accessory_detect_xcvr

/* File: dv/uadx_acc_model.sv */
`timescale 1ns/100ps
module uadx_acc_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Connector state asked for by the bench
  input  wire logic [7:0] plug_state,
  // Detector and receive lines into the device
  output logic            vbus_valid_comparator,
  output logic            vbus_session_high_comparator,
  output logic            vbus_session_low_comparator,
  output logic            dp_above_thresh,
  output logic            dm_above_thresh,
  output logic            id_float_det,
  output logic            id_gnd_det,
  output logic            id_special_det,
  output logic            rx_diff_in,
  // Transmit lines from the device
  input  wire logic       positive_data_line_o,
  input  wire logic       negative_data_line_o,
  input  wire logic       tx_busy,
  // Line statistics for the bench
  output logic [7:0]      toggle_count,
  output logic            diff_bad
);
  logic       prev_q;
  logic       busy_q;
  logic       busy2_q;
  logic [7:0] tgl_q;
  logic       bad_q;
  // Detector levels follow the plug
  assign {id_special_det, id_gnd_det, id_float_det, dm_above_thresh,
          dp_above_thresh, vbus_session_low_comparator,
          vbus_session_high_comparator, vbus_valid_comparator} = plug_state;
  // Receive level tied to the inverted supply pin so the raw path can be seen
  assign rx_diff_in   = ~plug_state[0];
  assign toggle_count = tgl_q;
  assign diff_bad     = bad_q;
  // Busy tail kept two cycles: the line lags the level register by one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= 1'b1;
      busy_q  <= 1'b0;
      busy2_q <= 1'b0;
      tgl_q   <= 8'h00;
      bad_q   <= 1'b0;
    end else begin
      prev_q  <= positive_data_line_o;
      busy_q  <= tx_busy;
      busy2_q <= busy_q;
      if ((tx_busy || busy_q || busy2_q) &&
          positive_data_line_o !== prev_q) begin
        tgl_q <= tgl_q + 8'h01;
      end
      if (tx_busy && positive_data_line_o === negative_data_line_o) begin
        bad_q <= 1'b1;
      end
    end
  end
endmodule // uadx_acc_model

/* File: verilog/uadx_pkg.sv */
package uadx_pkg;
  // Register byte offsets
  localparam logic [7:0] UADX_OFF_SENSE = 8'h00;
  localparam logic [7:0] UADX_OFF_STAT  = 8'h04;
  localparam logic [7:0] UADX_OFF_MASK  = 8'h08;
  localparam logic [7:0] UADX_OFF_CTRL  = 8'h0C;
  localparam logic [7:0] UADX_OFF_TXD   = 8'h10;
  localparam logic [7:0] UADX_OFF_PLUG  = 8'h14;
  // Sense field positions
  localparam int UADX_S_VALID = 0;
  localparam int UADX_S_SESSH = 1;
  localparam int UADX_S_SESSL = 2;
  localparam int UADX_S_SE1   = 3;
  localparam int UADX_S_IDFLT = 4;
  localparam int UADX_S_IDGND = 5;
  // Status and mask field positions
  localparam int UADX_I_VBUS = 0;
  localparam int UADX_I_SE1  = 1;
  localparam int UADX_I_ID   = 2;
  // Control field positions
  localparam int UADX_C_XEN   = 0;
  localparam int UADX_C_SE0M  = 1;
  localparam int UADX_C_DIR   = 2;
  localparam int UADX_C_TXENN = 3;
  localparam int UADX_C_FS    = 4;
  localparam int UADX_C_SUSP  = 5;
  localparam int UADX_C_AUD0  = 6;
  localparam int UADX_C_AUD1  = 7;
  localparam int UADX_C_ADCEN = 8;
  // Reset values
  localparam logic [8:0] UADX_CTRL_RST = 9'h008;
  localparam logic [2:0] UADX_MASK_RST = 3'h0;
  // Stuffing limit: ones before a forced zero
  localparam logic [2:0] UADX_STUFF_RUN = 3'h6;
  // Bit time: 12 Mb/s nominal at 125 MHz rounds down to 10 cycles
  localparam int UADX_CLK_MHZ  = 125;
  localparam int UADX_BIT_MBPS = 12;
  localparam logic [3:0] UADX_BIT_CYC =
    4'(UADX_CLK_MHZ / UADX_BIT_MBPS);
  typedef enum logic [1:0] {
    UADX_PLUG_NONE  = 2'b00,
    UADX_PLUG_MINIA = 2'b01,
    UADX_PLUG_MINIB = 2'b10,
    UADX_PLUG_SPEC  = 2'b11
  } uadx_plug_t;
  typedef enum logic [1:0] {
    UADX_AUD_OFF    = 2'b00,
    UADX_AUD_MONO   = 2'b01,
    UADX_AUD_STEREO = 2'b10
  } uadx_aud_t;
endpackage

/* File: verilog/uadx_top.sv */
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Three comparators watch the bus supply
// - Each comparator has its own sense bit
// - Any supply comparator edge raises interrupt
// - Both data lines high set single-ended-one
// - Single-ended-one change raises interrupt
// - ID floating/grounded sense; change raises interrupt
// - ID decodes mini-A, mini-B, special modes
// - ID voltage routed to converter channel
// - Transceiver enabled only by enable bit
// - Two bits select four data modes
// - Transmit enable low disables receiver
// - Speed bit picks pull-up data line
// - Suspend bit puts transceiver low power
// - NRZI: one holds level, zero toggles
// - Zero stuffed after six ones
// - Mono and stereo audio on data lines
module uadx_top
  import uadx_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Detector inputs from analog
  input  wire logic        vbus_valid_comparator,
  input  wire logic        vbus_session_high_comparator,
  input  wire logic        vbus_session_low_comparator,
  input  wire logic        dp_above_thresh,
  input  wire logic        dm_above_thresh,
  input  wire logic        id_float_det,
  input  wire logic        id_gnd_det,
  input  wire logic        id_special_det,
  // Transceiver and line control
  input  wire logic        rx_diff_in,
  output logic             rx_data,
  output logic             xcvr_enable,
  output logic             xcvr_low_power,
  output logic             tx_driver_en,
  output logic             rx_receiver_en,
  output logic             positive_data_line_o,
  output logic             negative_data_line_o,
  output logic [1:0]       data_mode,
  output logic             pullup_positive_en,
  output logic             pullup_negative_en,
  output logic [1:0]       audio_mode,
  output logic             id_voltage_adc_channel,
  output logic             tx_busy,
  // Interrupt
  output logic             irq
);

  // Two-flop synchronisers for the nine detector and receive inputs
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign async_in = {rx_diff_in, id_special_det, id_gnd_det, id_float_det,
                     dm_above_thresh, dp_above_thresh,
                     vbus_session_low_comparator,
                     vbus_session_high_comparator, vbus_valid_comparator};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Live sense word
  logic [5:0] sense;
  logic       id_special;
  logic       rx_line;
  assign sense[UADX_S_VALID] = sync2_q[0];
  assign sense[UADX_S_SESSH] = sync2_q[1];
  assign sense[UADX_S_SESSL] = sync2_q[2];
  assign sense[UADX_S_SE1]   = sync2_q[3] & sync2_q[4];
  assign sense[UADX_S_IDFLT] = sync2_q[5];
  assign sense[UADX_S_IDGND] = sync2_q[6];
  assign id_special          = sync2_q[7];
  assign rx_line             = sync2_q[8];

  // Previous sense for edge detection
  logic [5:0] sense_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= 6'h00;
    end else begin
      sense_q <= sense;
    end
  end

  logic [2:0] evt;
  logic [5:0] chg;
  assign chg = sense ^ sense_q;
  assign evt[UADX_I_VBUS] = |chg[2:0];
  assign evt[UADX_I_SE1]  = chg[UADX_S_SE1];
  assign evt[UADX_I_ID]   = |chg[5:4];

  // Plug type from ID state
  uadx_plug_t plug;
  always_comb begin
    if (id_special) begin
      plug = UADX_PLUG_SPEC;
    end else if (sense[UADX_S_IDGND]) begin
      plug = UADX_PLUG_MINIA;
    end else if (sense[UADX_S_IDFLT]) begin
      plug = UADX_PLUG_MINIB;
    end else begin
      plug = UADX_PLUG_NONE;
    end
  end

  // APB decode; zero wait states
  logic wr_en;
  logic rd_en;
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite;

  logic addr_ok;
  always_comb begin
    case (paddr)
      UADX_OFF_SENSE, UADX_OFF_STAT, UADX_OFF_MASK,
      UADX_OFF_CTRL, UADX_OFF_TXD, UADX_OFF_PLUG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // Status, mask, control
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic [8:0] ctrl_q;
  logic [2:0] w1c;
  assign w1c = (wr_en && paddr == UADX_OFF_STAT) ? pwdata[2:0] : 3'h0;

  // Set beats clear so no edge is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~w1c) | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= UADX_MASK_RST;
    end else if (wr_en && paddr == UADX_OFF_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= UADX_CTRL_RST;
    end else if (wr_en && paddr == UADX_OFF_CTRL) begin
      ctrl_q <= pwdata[8:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // Transmit byte write starts a serialiser
  logic       txd_wr;
  logic       can_tx;
  assign txd_wr = wr_en && paddr == UADX_OFF_TXD;

  // Read mux, registered data out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      case (paddr)
        UADX_OFF_SENSE: prdata <= {26'h0, sense};
        UADX_OFF_STAT:  prdata <= {29'h0, stat_q};
        UADX_OFF_MASK:  prdata <= {29'h0, mask_q};
        UADX_OFF_CTRL:  prdata <= {23'h0, ctrl_q};
        UADX_OFF_TXD:   prdata <= {31'h0, tx_busy};
        UADX_OFF_PLUG:  prdata <= {30'h0, plug};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Transceiver control outputs
  logic txen_n;
  assign txen_n = ctrl_q[UADX_C_TXENN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcvr_enable        <= 1'b0;
      xcvr_low_power     <= 1'b0;
      tx_driver_en       <= 1'b0;
      rx_receiver_en     <= 1'b0;
      data_mode          <= 2'b00;
      pullup_positive_en <= 1'b0;
      pullup_negative_en <= 1'b0;
      audio_mode         <= UADX_AUD_OFF;
      id_voltage_adc_channel <= 1'b0;
    end else begin
      xcvr_enable    <= ctrl_q[UADX_C_XEN];
      xcvr_low_power <= ctrl_q[UADX_C_SUSP];
      tx_driver_en   <= ctrl_q[UADX_C_XEN] & ~txen_n
                        & ~ctrl_q[UADX_C_SUSP];
      rx_receiver_en <= ctrl_q[UADX_C_XEN] & txen_n;
      data_mode      <= {ctrl_q[UADX_C_DIR],
                         ctrl_q[UADX_C_SE0M]};
      pullup_positive_en <= ctrl_q[UADX_C_XEN]
                            & ctrl_q[UADX_C_FS];
      pullup_negative_en <= ctrl_q[UADX_C_XEN]
                            & ~ctrl_q[UADX_C_FS];
      // Stereo wins if both audio bits set
      if (ctrl_q[UADX_C_AUD1]) begin
        audio_mode <= UADX_AUD_STEREO;
      end else if (ctrl_q[UADX_C_AUD0]) begin
        audio_mode <= UADX_AUD_MONO;
      end else begin
        audio_mode <= UADX_AUD_OFF;
      end
      id_voltage_adc_channel <= ctrl_q[UADX_C_ADCEN];
    end
  end

  // Received line passes only while receiver on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 1'b0;
    end else begin
      rx_data <= rx_line & rx_receiver_en;
    end
  end

  // Serialiser: LSB first, stuffing, NRZI
  logic [7:0] sh_q;
  logic [3:0] nbits_q;
  logic [2:0] ones_q;
  logic [3:0] tick_q;
  logic       lvl_q;
  logic       stuff_now;
  logic       bit_end;
  assign can_tx    = tx_driver_en;
  assign tx_busy   = nbits_q != 4'h0;
  assign bit_end   = tick_q == UADX_BIT_CYC - 4'h1;
  assign stuff_now = ones_q == UADX_STUFF_RUN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 4'h0;
    end else if (!tx_busy || bit_end) begin
      tick_q <= 4'h0;
    end else begin
      tick_q <= tick_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q    <= 8'h00;
      nbits_q <= 4'h0;
      ones_q  <= 3'h0;
      lvl_q   <= 1'b1;
    end else if (txd_wr && !tx_busy && can_tx) begin
      sh_q    <= pwdata[7:0];
      nbits_q <= 4'h8;
    end else if (tx_busy && bit_end) begin
      if (stuff_now) begin
        lvl_q  <= ~lvl_q;
        ones_q <= 3'h0;
      end else begin
        if (sh_q[0]) begin
          ones_q <= ones_q + 3'h1;
        end else begin
          lvl_q  <= ~lvl_q;
          ones_q <= 3'h0;
        end
        sh_q    <= {1'b0, sh_q[7:1]};
        nbits_q <= nbits_q - 4'h1;
      end
    end
  end

  // Differential drive from NRZI level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positive_data_line_o <= 1'b1;
      negative_data_line_o <= 1'b0;
    end else begin
      positive_data_line_o <= lvl_q;
      negative_data_line_o <= ~lvl_q;
    end
  end

  // Sticky bit holds until cleared
  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    $past(stat_q[0]) && !$past(w1c[0]) |-> stat_q[0])
    else $error("status bit dropped without clear");
  a_vbus_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(sense[0]) |=> stat_q[UADX_I_VBUS])
    else $error("supply edge not flagged");
  a_se1_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(sense[UADX_S_SE1]) |=> stat_q[UADX_I_SE1])
    else $error("single-ended-one change not flagged");
  a_id_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(sense[UADX_S_IDGND]) |=> stat_q[UADX_I_ID])
    else $error("id change not flagged");
  a_rx_off_tx: assert property (@(posedge pclk) disable iff (!presetn)
    !(tx_driver_en && rx_receiver_en))
    else $error("receiver and transmitter both on");
  a_xcvr_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 xcvr_enable == $past(ctrl_q[UADX_C_XEN]))
    else $error("transceiver enable does not follow bit");
  a_pullup_one: assert property (@(posedge pclk) disable iff (!presetn)
    !(pullup_positive_en && pullup_negative_en))
    else $error("both pull-ups on");
  sequence s_six_ones;
    ones_q == UADX_STUFF_RUN && tx_busy && bit_end;
  endsequence
  a_stuff_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_six_ones |=> ones_q == 3'h0 && lvl_q != $past(lvl_q))
    else $error("no stuffed zero after six ones");
  a_nrzi_one: assert property (@(posedge pclk) disable iff (!presetn)
    tx_busy && bit_end && !stuff_now && sh_q[0] |=> $stable(lvl_q))
    else $error("one toggled the line");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(stat_q & mask_q))
    else $error("interrupt level wrong");
  // Control bits reach the pins one cycle later
  a_susp_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 xcvr_low_power == $past(ctrl_q[UADX_C_SUSP]))
    else $error("low power does not follow suspend bit");
  a_susp_no_tx: assert property (@(posedge pclk) disable iff (!presetn)
    xcvr_low_power |-> !tx_driver_en)
    else $error("transmitter on while suspended");
  a_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 data_mode ==
      $past({ctrl_q[UADX_C_DIR], ctrl_q[UADX_C_SE0M]}))
    else $error("data mode does not follow control bits");
  a_rx_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 rx_receiver_en == (xcvr_enable && $past(txen_n)))
    else $error("receiver enable wrong");
  a_valid_sense: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sense[UADX_S_VALID] == $past(vbus_valid_comparator, 2))
    else $error("valid sense not live");
  a_se1_sense: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sense[UADX_S_SE1] ==
      $past(dp_above_thresh & dm_above_thresh, 2))
    else $error("single-ended-one sense not live");
  a_idflt_sense: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sense[UADX_S_IDFLT] == $past(id_float_det, 2))
    else $error("id floating sense not live");
  a_stereo_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[UADX_C_AUD1] |=> audio_mode == UADX_AUD_STEREO)
    else $error("stereo not selected");
  a_adc_route: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[UADX_C_ADCEN] |=> id_voltage_adc_channel)
    else $error("id voltage not routed");
  // Byte accepted only when idle and transmitter on
  sequence s_tx_load;
    txd_wr && !tx_busy && can_tx;
  endsequence
  a_tx_load: assert property (@(posedge pclk) disable iff (!presetn)
    s_tx_load |=> tx_busy && sh_q == $past(pwdata[7:0]))
    else $error("transmit byte not latched");

endmodule // uadx_top
